// ### shared/arf_map.vh
// constants for the asynchronous receive formatter: codes, field positions
// assumes inclusion by bare name from the design files; bench files use literal codes
// Behaviour
// [RULE_01] ack complete is code 0001
// [RULE_02] ack pending 0010, never for responses
// [RULE_03] busy codes 0100, 0101, 0110 by phase
// [RULE_04] 1101 for bad block payload only
// [RULE_05] 1110 for bad header or transaction
// [RULE_06] link-supplied reserved codes pass unchanged
// [RULE_07] host treats broadcast non-data-error as good
// [RULE_08] no-data entry: three header quadlets, status
// [RULE_09] quadlet entry: four quadlets, then status
// [RULE_10] block entry: header, data, then status
// [RULE_11] self-ID/PHY entries get header tcode E
// [RULE_12] self-ID entry holds whole self-ID string
// [RULE_13] self-ID check quadlets kept, not verified
// [RULE_14] host verifies self-ID check quadlets itself
// [RULE_15] self-ID status data error or complete
// [RULE_16] PHY entry: first quadlet, check verified, dropped
// [RULE_17] confirmation record after every transmission
// [RULE_18] confirmations go to request/response queue
// [RULE_19] confirmation 1 complete/broadcast, 2 pending
// [RULE_20] confirmation 4 retry, D and E errors
// [RULE_21] exactly one confirmation per sent packet
// [RULE_22] block tail zero padded, first byte high
// [RULE_23] no acknowledge gives confirmation code 0
// [RULE_24] entry visible only after status quadlet
`ifndef ARF_MAP_VH
`define ARF_MAP_VH
// acknowledge codes
`define ARF_ACK_COMPLETE 4'h1
`define ARF_ACK_PENDING 4'h2
`define ARF_ACK_BUSY_X 4'h4
`define ARF_ACK_BUSY_A 4'h5
`define ARF_ACK_BUSY_B 4'h6
`define ARF_ACK_DATA_ERR 4'hD
`define ARF_ACK_TYPE_ERR 4'hE
// confirmation codes
`define ARF_CF_NOACK 4'h0
`define ARF_CF_DONE 4'h1
`define ARF_CF_PEND 4'h2
`define ARF_CF_RETRY 4'h4
`define ARF_CF_DATA_ERR 4'hD
`define ARF_CF_TYPE_ERR 4'hE
// transaction codes
`define ARF_TC_QWR_REQ 4'h0
`define ARF_TC_BWR_REQ 4'h1
`define ARF_TC_WR_RSP 4'h2
`define ARF_TC_QRD_REQ 4'h4
`define ARF_TC_BRD_REQ 4'h5
`define ARF_TC_QRD_RSP 4'h6
`define ARF_TC_BRD_RSP 4'h7
`define ARF_TC_CONF 4'h8
`define ARF_TC_LK_REQ 4'h9
`define ARF_TC_LK_RSP 4'hB
`define ARF_TC_SELF_PHY 4'hE
// field positions
`define ARF_TC_LSB 4
`define ARF_LEN_LSB 16
// received packet classes
`define ARF_PK_NORMAL 2'h0
`define ARF_PK_SELFID 2'h1
`define ARF_PK_PHY 2'h2
// busy phase selector
`define ARF_BUSY_PH_X 2'h0
`define ARF_BUSY_PH_A 2'h1
`define ARF_BUSY_PH_B 2'h2
// queue buffer width: data, destination, last
`define ARF_BUF_W 34
`endif

// ### verilog/arf_buf2.v
// two-entry elastic buffer between formatter and receive queues
// assumes both sides on clk; head word comes straight from a register
`timescale 1ns/1ps
`default_nettype none
module arf_buf2 #(
    parameter WIDTH = 34
) (
    input wire clk,
    input wire rst_b,
    input wire in_valid,
    output wire in_ready,
    input wire [WIDTH-1:0] in_data,
    output wire out_valid,
    input wire out_ready,
    output wire [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] head; // oldest word, drives out_data
    reg [WIDTH-1:0] tail; // second word when full
    reg [1:0] cnt; // words held, 0..2
    wire push;
    wire pop;

    assign in_ready = (cnt != 2'h2);
    assign out_valid = (cnt != 2'h0);
    assign out_data = head;
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;

    // occupancy and storage; full means the source stalls, no word lost
    always @(posedge clk) begin
        if (!rst_b) begin
            cnt <= 2'h0;
            head <= {WIDTH{1'b0}};
            tail <= {WIDTH{1'b0}};
        end else begin
            if (push && pop) begin
                // one in, one out: head moves on
                if (cnt == 2'h1) begin
                    head <= in_data;
                end else begin
                    head <= tail;
                    tail <= in_data;
                end
            end else if (push) begin
                // fill the first free slot
                if (cnt == 2'h0) begin
                    head <= in_data;
                end else begin
                    tail <= in_data;
                end
                cnt <= cnt + 2'h1;
            end else if (pop) begin
                // drain: tail shifts to head
                head <= tail;
                cnt <= cnt - 2'h1;
            end
        end
    end
endmodule // arf_buf2
`default_nettype wire

// ### verilog/arf_receive_formatter.v
// asynchronous receive formatter: builds receive queue entries and
// transmit confirmations, feeds request and response queues
// assumes packet stream, flags and confirmations come from logic on clk
`timescale 1ns/1ps
`default_nettype none
`include "arf_map.vh"
module arf_receive_formatter (
    input wire clk,
    input wire rst_b,
    // bus reset from the link core, same clock
    input wire bus_reset,
    // received packet stream, wire order, one quadlet a beat
    input wire rx_valid,
    output wire rx_ready,
    input wire [31:0] rx_data,
    input wire rx_last,
    input wire [1:0] rx_class,
    // packet verdict, valid with the last beat
    input wire rx_crc_err,
    input wire rx_hdr_err,
    input wire rx_busy,
    input wire [1:0] rx_busy_phase,
    input wire rx_rsp_later,
    input wire rx_link_ack_vld,
    input wire [3:0] rx_link_ack,
    input wire rx_misalign,
    input wire rx_overrun,
    // transmit outcome, one per transmitted packet
    input wire cf_valid,
    output wire cf_ready,
    input wire cf_rsp,
    input wire cf_bcast,
    input wire cf_noack,
    input wire cf_retry_exp,
    input wire [3:0] cf_ack,
    input wire [23:0] cf_tag,
    // request receive queue write port
    output wire req_q_valid,
    input wire req_q_ready,
    output wire [31:0] req_q_data,
    output wire req_q_last,
    // response receive queue write port
    output wire rsp_q_valid,
    input wire rsp_q_ready,
    output wire [31:0] rsp_q_data,
    output wire rsp_q_last
);
    localparam ST_IDLE = 2'h0; // between entries
    localparam ST_SYNH = 2'h1; // synthesized header for self-ID or PHY
    localparam ST_PASS = 2'h2; // copying packet quadlets
    localparam ST_STAT = 2'h3; // closing status quadlet

    reg [1:0] state; // formatter state
    reg [1:0] pk; // class of the entry in progress
    reg [15:0] idx; // quadlet index within the packet
    reg [3:0] tcode; // transaction code of the entry
    reg [15:0] len; // block data length in bytes
    reg [14:0] dcnt; // block data quadlets seen
    reg [31:0] phy_first; // first PHY quadlet, for the check compare
    reg phy_bad; // PHY check quadlet mismatch
    reg dest_rsp; // entry goes to the response queue
    reg [3:0] ack; // code for the status quadlet

    reg buf_in_valid; // into the elastic buffer
    reg [31:0] buf_word;
    reg buf_last;
    reg buf_dest;
    reg rx_take; // rx_ready while copying
    wire buf_in_ready;
    wire buf_out_valid;
    wire buf_out_ready;
    wire [`ARF_BUF_W-1:0] buf_out;
    wire beat;

    reg [3:0] next_ack; // verdict computed at the last beat
    reg [3:0] cf_code; // confirmation code
    reg [31:0] pad_word; // data quadlet after tail padding

    // decoded packet type of the current beat or the latched header
    wire [3:0] tc_now = (idx == 16'h0000) ? rx_data[`ARF_TC_LSB+3:`ARF_TC_LSB] : tcode;
    wire is_blk = (tc_now == `ARF_TC_BWR_REQ) | (tc_now == `ARF_TC_BRD_RSP) |
                  (tc_now == `ARF_TC_LK_REQ) | (tc_now == `ARF_TC_LK_RSP);
    wire is_rsp = (tc_now == `ARF_TC_WR_RSP) | (tc_now == `ARF_TC_QRD_RSP) |
                  (tc_now == `ARF_TC_BRD_RSP) | (tc_now == `ARF_TC_LK_RSP);
    wire normal = (pk == `ARF_PK_NORMAL);
    // length as of this beat; the fourth quadlet may carry it right now
    wire [15:0] len_now = (idx == 16'h0003) ? rx_data[`ARF_LEN_LSB+15:`ARF_LEN_LSB] : len;
    wire [14:0] exp_q = len_now[15:2] + {14'h0000, (len_now[1:0] != 2'h0)};
    wire in_data = normal & is_blk & (idx >= 16'h0004);
    wire [14:0] dcnt_now = dcnt + {14'h0000, in_data};
    wire payload = normal & is_blk & ((len_now != 16'h0000) | (dcnt_now != 15'h0000));
    wire skip = (pk == `ARF_PK_PHY) & (idx == 16'h0001);

    assign rx_ready = (state == ST_PASS) & rx_take;
    assign beat = rx_valid & rx_ready;
    assign cf_ready = (state == ST_IDLE) & buf_in_ready;

    // padding: keep only the bytes the length covers, first byte high
    always @* begin
        pad_word = rx_data;
        if (in_data && (dcnt_now == exp_q)) begin
            case (len_now[1:0])
                2'h1: pad_word = {rx_data[31:24], 24'h000000}; // [RULE_22]
                2'h2: pad_word = {rx_data[31:16], 16'h0000}; // [RULE_22]
                2'h3: pad_word = {rx_data[31:8], 8'h00}; // [RULE_22]
                default: pad_word = rx_data; // whole quadlet
            endcase
        end
    end

    // acknowledge verdict; link-supplied codes win for normal packets so newer ones survive
    always @* begin
        next_ack = `ARF_ACK_COMPLETE; // [RULE_01]
        if (pk == `ARF_PK_SELFID) begin
            // string complete unless misaligned or overrun
            if (rx_misalign || rx_overrun) begin
                next_ack = `ARF_ACK_DATA_ERR; // [RULE_15]
            end else begin
                next_ack = `ARF_ACK_COMPLETE; // [RULE_15]
            end
        end else if (pk == `ARF_PK_PHY) begin
            // PHY check verdict: check quadlet compared on this beat, or the mismatch latched earlier
            if (phy_bad || (skip && (rx_data != ~phy_first))) begin
                next_ack = `ARF_ACK_DATA_ERR; // [RULE_16]
            end
        end else if (rx_link_ack_vld) begin
            next_ack = rx_link_ack; // [RULE_06]
        end else if (rx_hdr_err) begin
            next_ack = `ARF_ACK_TYPE_ERR; // [RULE_05]
        end else if (payload && (rx_crc_err || (dcnt_now != exp_q))) begin
            // among normal packets, only those that carry a data block can earn this code here
            next_ack = `ARF_ACK_DATA_ERR; // [RULE_04]
        end else if (rx_busy) begin
            case (rx_busy_phase)
                `ARF_BUSY_PH_A: next_ack = `ARF_ACK_BUSY_A; // [RULE_03]
                `ARF_BUSY_PH_B: next_ack = `ARF_ACK_BUSY_B; // [RULE_03]
                default: next_ack = `ARF_ACK_BUSY_X; // [RULE_03]
            endcase
        end else if (rx_rsp_later && !is_rsp) begin
            // responses never get pending
            next_ack = `ARF_ACK_PENDING; // [RULE_02]
        end
    end

    // confirmation code from the transmit outcome
    always @* begin
        cf_code = `ARF_CF_RETRY;
        if (cf_retry_exp) begin
            cf_code = `ARF_CF_RETRY; // [RULE_20]
        end else if (cf_bcast) begin
            cf_code = `ARF_CF_DONE; // [RULE_19]
        end else if (cf_noack) begin
            cf_code = `ARF_CF_NOACK; // [RULE_23]
        end else begin
            case (cf_ack)
                `ARF_ACK_COMPLETE: cf_code = `ARF_CF_DONE; // [RULE_19]
                `ARF_ACK_PENDING: cf_code = `ARF_CF_PEND; // [RULE_19]
                `ARF_ACK_DATA_ERR: cf_code = `ARF_CF_DATA_ERR; // [RULE_20]
                `ARF_ACK_TYPE_ERR: cf_code = `ARF_CF_TYPE_ERR; // [RULE_20]
                default: cf_code = `ARF_CF_RETRY; // busy left over: not accepted
            endcase
        end
    end

    // what goes into the buffer this cycle
    always @* begin
        buf_in_valid = 1'b0;
        buf_word = 32'h00000000;
        buf_last = 1'b0;
        buf_dest = dest_rsp;
        rx_take = 1'b0;
        case (state)
            ST_IDLE: begin
                // one-beat confirmation record, steered by its kind
                buf_in_valid = cf_valid; // [RULE_17]
                buf_word = {cf_tag, `ARF_TC_CONF, cf_code}; // [RULE_17]
                buf_last = 1'b1;
                buf_dest = cf_rsp; // [RULE_18]
            end
            ST_SYNH: begin
                // synthesized header; self-ID and PHY use the request queue
                buf_in_valid = 1'b1;
                buf_word = {24'h000000, `ARF_TC_SELF_PHY, 4'h0}; // [RULE_11]
            end
            ST_PASS: begin
                if (skip) begin
                    // PHY check quadlet: consumed, never queued
                    rx_take = 1'b1; // [RULE_16]
                end else begin
                    // header and data quadlets in wire order
                    buf_in_valid = rx_valid; // [RULE_08] [RULE_09] [RULE_10]
                    buf_word = pad_word; // [RULE_12] [RULE_13]
                    rx_take = buf_in_ready;
                    if (normal && (idx == 16'h0000)) begin
                        buf_dest = is_rsp;
                    end
                end
            end
            ST_STAT: begin
                // status closes the entry; last marks it visible
                buf_in_valid = 1'b1;
                buf_word = {28'h0000000, ack}; // [RULE_08] [RULE_09] [RULE_10]
                buf_last = 1'b1; // [RULE_24]
            end
            default: begin
                buf_in_valid = 1'b0;
            end
        endcase
    end

    // sequencing of one entry
    always @(posedge clk) begin
        if (!rst_b) begin
            state <= ST_IDLE;
            pk <= `ARF_PK_NORMAL;
            idx <= 16'h0000;
            tcode <= 4'h0;
            len <= 16'h0000;
            dcnt <= 15'h0000;
            phy_first <= 32'h00000000;
            phy_bad <= 1'b0;
            dest_rsp <= 1'b0;
            ack <= `ARF_ACK_COMPLETE;
        end else begin
            case (state)
                ST_IDLE: begin
                    // confirmations first, so one waits behind at most the entry in progress
                    if (!cf_valid && rx_valid && !bus_reset) begin
                        pk <= rx_class;
                        idx <= 16'h0000;
                        dcnt <= 15'h0000;
                        len <= 16'h0000;
                        phy_bad <= 1'b0;
                        dest_rsp <= 1'b0;
                        if (rx_class == `ARF_PK_NORMAL) begin
                            state <= ST_PASS;
                        end else begin
                            state <= ST_SYNH;
                        end
                    end
                end
                ST_SYNH: begin
                    if (bus_reset) begin
                        // cut short: entry closed with a data error
                        ack <= `ARF_ACK_DATA_ERR;
                        state <= ST_STAT;
                    end else if (buf_in_ready) begin
                        state <= ST_PASS;
                    end
                end
                ST_PASS: begin
                    if (bus_reset) begin
                        ack <= `ARF_ACK_DATA_ERR;
                        state <= ST_STAT;
                    end else if (beat) begin
                        if (idx != 16'hFFFF) begin
                            idx <= idx + 16'h0001;
                        end
                        if (normal && (idx == 16'h0000)) begin
                            tcode <= rx_data[`ARF_TC_LSB+3:`ARF_TC_LSB];
                            dest_rsp <= is_rsp;
                        end
                        if (normal && is_blk && (idx == 16'h0003)) begin
                            len <= rx_data[`ARF_LEN_LSB+15:`ARF_LEN_LSB]; // [RULE_10]
                        end
                        if (in_data && (dcnt != 15'h7FFF)) begin
                            dcnt <= dcnt_now;
                        end
                        if ((pk == `ARF_PK_PHY) && (idx == 16'h0000)) begin
                            phy_first <= rx_data;
                        end
                        if (skip && (rx_data != ~phy_first)) begin
                            phy_bad <= 1'b1; // [RULE_16]
                        end
                        if (rx_last) begin
                            ack <= next_ack;
                            state <= ST_STAT;
                        end
                    end
                end
                ST_STAT: begin
                    if (buf_in_ready) begin
                        state <= ST_IDLE;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // elastic buffer: a queue stall backs up into rx_ready and cf_ready
    arf_buf2 #(
        .WIDTH(`ARF_BUF_W)
    ) u_buf (
        .clk(clk),
        .rst_b(rst_b),
        .in_valid(buf_in_valid),
        .in_ready(buf_in_ready),
        .in_data({buf_last, buf_dest, buf_word}),
        .out_valid(buf_out_valid),
        .out_ready(buf_out_ready),
        .out_data(buf_out)
    );

    // steer the head word to its queue; bit 32 selects responses
    assign buf_out_ready = buf_out[32] ? rsp_q_ready : req_q_ready;
    assign req_q_valid = buf_out_valid & ~buf_out[32]; // [RULE_18]
    assign rsp_q_valid = buf_out_valid & buf_out[32]; // [RULE_18]
    assign req_q_data = buf_out[31:0];
    assign rsp_q_data = buf_out[31:0];
    assign req_q_last = buf_out[33]; // [RULE_24]
    assign rsp_q_last = buf_out[33]; // [RULE_24]
endmodule // arf_receive_formatter
`default_nettype wire

// ### dv/arf_props.sv
// checker: port timing and record shape of the receive formatter
// assumes a bind onto arf_receive_formatter, one clock, rst_b low resets
`timescale 1ns/1ps
`default_nettype none
module arf_props (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic rx_valid,
    input wire logic rx_ready,
    input wire logic rx_last,
    input wire logic cf_valid,
    input wire logic cf_ready,
    input wire logic cf_rsp,
    input wire logic [23:0] cf_tag,
    input wire logic req_q_valid,
    input wire logic req_q_ready,
    input wire logic [31:0] req_q_data,
    input wire logic req_q_last,
    input wire logic rsp_q_valid,
    input wire logic rsp_q_ready,
    input wire logic [31:0] rsp_q_data,
    input wire logic rsp_q_last
);
    default clocking dc @(posedge clk); endclocking
    default disable iff (!rst_b);
    logic [23:0] tag_q; // last accepted tag
    // record may leave the buffer later
    always @(posedge clk) begin
        if (!rst_b)
            tag_q <= 24'h000000;
        else if (cf_valid && cf_ready)
            tag_q <= cf_tag;
    end
    AST_REQ_HOLD: assert property (
        req_q_valid && !req_q_ready |=> req_q_valid && $stable({req_q_last, req_q_data}))
        else $error("request head moved while stalled");
    AST_RSP_HOLD: assert property (
        rsp_q_valid && !rsp_q_ready |=> rsp_q_valid && $stable({rsp_q_last, rsp_q_data}))
        else $error("response head moved while stalled");
    AST_ONE_QUEUE: assert property (
        !(req_q_valid && rsp_q_valid))
        else $error("one word offered to both queues");
    AST_RX_CF_EXCL: assert property (
        !(rx_ready && cf_ready))
        else $error("confirmation accepted inside an entry");
    AST_STAT_GAP: assert property (
        rx_valid && rx_ready && rx_last |=> !rx_ready && !cf_ready ##1 !rx_ready)
        else $error("no status slot after last beat");
    AST_STATUS_SHAPE: assert property (
        req_q_valid && req_q_last |-> req_q_data[7:4] == 4'h8 || req_q_data[31:4] == 28'h0)
        else $error("entry end is neither status nor record");
    AST_RSP_NO_PEND: assert property (
        rsp_q_valid && rsp_q_last && rsp_q_data[7:4] == 4'h0 |-> rsp_q_data[3:0] != 4'h2)
        else $error("pending code on a response");
    AST_CONF_REQ: assert property (
        cf_valid && cf_ready && !cf_rsp |=> ##[0:40] req_q_valid && req_q_ready
        && req_q_last && req_q_data[31:4] == {tag_q, 4'h8})
        else $error("request confirmation missing");
    AST_CONF_RSP: assert property (
        cf_valid && cf_ready && cf_rsp |=> ##[0:40] rsp_q_valid && rsp_q_ready
        && rsp_q_last && rsp_q_data[31:4] == {tag_q, 4'h8})
        else $error("response confirmation missing");
    // main scenarios reached
    cover property (rx_valid && rx_ready && rx_last);
    cover property (cf_valid && cf_ready && cf_rsp);
    cover property (req_q_valid && !req_q_ready);
endmodule // arf_props
`default_nettype wire

// ### dv/arf_host_model.sv
// host model: drains request and response receive queues into lists
// assumes formatter queue ports on clk; stall holds both readies low
`timescale 1ns/1ps
`default_nettype none
module arf_host_model (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic stall,
    input wire logic req_q_valid,
    input wire logic [31:0] req_q_data,
    input wire logic req_q_last,
    output logic req_q_ready,
    input wire logic rsp_q_valid,
    input wire logic [31:0] rsp_q_data,
    input wire logic rsp_q_last,
    output logic rsp_q_ready
);
    logic [32:0] req_got [$]; // taken words, last flag on top
    logic [32:0] rsp_got [$];
    // stall holds the head word
    assign req_q_ready = rst_b && !stall;
    assign rsp_q_ready = rst_b && !stall;
    // collect each word on the edge that takes it
    always @(posedge clk) begin
        if (req_q_valid && req_q_ready)
            req_got.push_back({req_q_last, req_q_data});
        if (rsp_q_valid && rsp_q_ready)
            rsp_got.push_back({rsp_q_last, rsp_q_data});
    end
endmodule // arf_host_model
`default_nettype wire

// ### dv/arf_receive_formatter_bench.sv
// testbench: entries, status codes, buffering and confirmations
// assumes arf_props and arf_host_model compiled first
`timescale 1ns/1ps
`default_nettype none
module arf_receive_formatter_bench;
    logic clk, rst_b, bus_reset, stall, rx_valid, rx_last, rx_crc_err, rx_hdr_err;
    logic rx_busy, rx_rsp_later, rx_link_ack_vld, rx_misalign, rx_overrun;
    logic cf_valid, cf_rsp, cf_bcast, cf_noack, cf_retry_exp;
    logic [1:0] rx_class, rx_busy_phase;
    logic [3:0] rx_link_ack, cf_ack;
    logic [23:0] cf_tag;
    logic [31:0] rx_data, msk; // msk trims the last data beat
    logic [31:0] pk [0:7]; // beats to send
    logic [31:0] ex [0:8]; // expected entry words
    wire rx_ready, cf_ready, req_q_valid, req_q_ready, req_q_last;
    wire rsp_q_valid, rsp_q_ready, rsp_q_last;
    wire [31:0] req_q_data, rsp_q_data;
    int err_count = 0, check_count = 0;
    // formatter and host, every port by its name
    arf_receive_formatter dut (.*);
    arf_host_model host (.*);
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic fail(input string m);
        err_count++;
        $display("Error %0t: %s", $time, m);
    endtask
    task automatic summarize;
        $display("checks %0d, mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic clear_verdict;
        {rx_crc_err, rx_hdr_err, rx_busy, rx_rsp_later, rx_link_ack_vld} = 5'h00;
        {rx_misalign, rx_overrun, rx_busy_phase, rx_link_ack} = 8'h00;
    endtask
    // each beat held until the edge that takes it
    task automatic send(input logic [1:0] cls, input int n);
        for (int i = 0; i < n; i++) begin
            {rx_valid, rx_last, rx_class, rx_data} = {1'b1, i == n - 1, cls, pk[i]};
            @(negedge clk);
            for (int t = 0; t < 100 && rx_ready !== 1'b1; t++)
                @(negedge clk);
            @(posedge clk) #1;
        end
        {rx_valid, rx_last} = 2'h0;
    endtask
    // compare the next m words of one queue with ex
    task automatic check_q(input logic rsp, input int m);
        logic [32:0] w;
        for (int i = 0; i < m; i++) begin
            for (int t = 0; t < 300 && (rsp ? host.rsp_got.size() : host.req_got.size()) == 0; t++)
                @(posedge clk) #1;
            w = rsp ? host.rsp_got.pop_front() : host.req_got.pop_front();
            check_count++;
            if (w !== {i == m - 1, ex[i]})
                fail($sformatf("word %0d got %h want %h", i, w, ex[i]));
        end
    endtask
    // build the expected entry, send the packet, check the entry
    task automatic run(input logic [1:0] cls, input int n, input logic rsp, input logic [3:0] st);
        int m;
        m = (cls != 2'h0);
        ex[0] = 32'h000000E0;
        for (int i = 0; i < (cls == 2'h2 ? 1 : n); i++)
            ex[m++] = pk[i];
        if (cls == 2'h0)
            ex[m - 1] = pk[n - 1] & msk;
        ex[m] = {28'h0000000, st};
        send(cls, n);
        check_q(rsp, m + 1);
        msk = 32'hFFFFFFFF;
    endtask
    task automatic t_quad;
        pk[0] = 32'hFFC00100;
        pk[1] = 32'hFFC1FFFF;
        pk[2] = 32'hF0000400;
        pk[3] = 32'h12345678;
        run(2'h0, 4, 1'b0, 4'h1);
    endtask
    // no-data read request under each verdict; write response eighth of nine
    task automatic t_acks;
        logic [3:0] want [0:8];
        want = '{4'hE, 4'h4, 4'h5, 4'h6, 4'h2, 4'hB, 4'h1, 4'h1, 4'h1};
        for (int k = 0; k < 9; k++) begin
            clear_verdict();
            pk[0] = (k == 7) ? 32'hFFC00120 : 32'hFFC00140;
            rx_hdr_err = (k == 0);
            rx_busy = (k >= 1 && k <= 3);
            rx_busy_phase = k[1:0] - 2'h1;
            rx_rsp_later = (k == 4 || k == 7);
            rx_link_ack_vld = (k == 5);
            rx_link_ack = 4'hB;
            rx_crc_err = (k == 8);
            run(2'h0, 3, k == 7, want[k]);
        end
        clear_verdict();
    endtask
    // block write, tail padded; buffer filled while the host stalls
    task automatic t_block;
        pk[3] = 32'h00050000;
        pk[4] = 32'h11223344;
        pk[5] = 32'hAABBCCDD;
        pk[0] = 32'hFFC00110;
        msk = 32'hFF000000;
        stall = 1'b1;
        fork
            run(2'h0, 6, 1'b0, 4'h1);
            begin
                repeat (12) @(negedge clk);
                check_count++;
                if (rx_ready !== 1'b0)
                    fail("beat taken with queues full");
                @(posedge clk) #1;
                stall = 1'b0;
            end
        join
        rx_crc_err = 1'b1;
        msk = 32'hFF000000;
        run(2'h0, 6, 1'b0, 4'hD);
        clear_verdict();
    endtask
    task automatic t_self;
        pk[0] = 32'h807F0A12;
        pk[1] = ~pk[0];
        pk[2] = 32'h81400C34;
        pk[3] = ~pk[2];
        for (int k = 0; k < 3; k++) begin
            {rx_overrun, rx_misalign} = {k == 1, k == 2};
            run(2'h1, 4, 1'b0, (k == 0) ? 4'h1 : 4'hD);
        end
        clear_verdict();
    endtask
    task automatic t_phy;
        pk[0] = 32'h40A00000;
        pk[1] = ~pk[0];
        run(2'h2, 2, 1'b0, 4'h1);
        pk[1] = pk[0];
        run(2'h2, 2, 1'b0, 4'hD);
    endtask
    // bus reset cuts an entry; status D closes it
    task automatic t_breset;
        {rx_valid, rx_class, rx_data} = {1'b1, 2'h0, pk[0]};
        repeat (2) @(posedge clk) #1;
        {rx_valid, bus_reset, ex[0], ex[1]} = {2'h1, pk[0], 32'hD};
        @(posedge clk) #1;
        bus_reset = 1'b0;
        check_q(1'b0, 2);
    endtask
    // one record per outcome, odd cases to the response queue
    task automatic t_conf;
        logic [6:0] cfg [0:7];
        logic [3:0] code [0:7];
        cfg = '{7'h44, 7'h01, 7'h02, 7'h51, 7'h0D, 7'h0E, 7'h21, 7'h03};
        code = '{4'h1, 4'h1, 4'h2, 4'h4, 4'hD, 4'hE, 4'h0, 4'h4};
        for (int k = 0; k < 8; k++) begin
            {cf_bcast, cf_noack, cf_retry_exp, cf_ack} = cfg[k];
            {cf_valid, cf_rsp, cf_tag} = {1'b1, k[0], 20'hC0DE0, k[3:0]};
            @(negedge clk);
            for (int t = 0; t < 100 && cf_ready !== 1'b1; t++)
                @(negedge clk);
            @(posedge clk) #1;
            cf_valid = 1'b0;
            ex[0] = {cf_tag, 4'h8, code[k]};
            check_q(k[0], 1);
        end
        repeat (5) @(posedge clk);
        check_count++;
        if (host.req_got.size() != 0 || host.rsp_got.size() != 0)
            fail("extra queue word");
    endtask
    initial begin
        {rst_b, bus_reset, stall, rx_valid, rx_last, cf_valid, cf_rsp} = 7'h00;
        {cf_bcast, cf_noack, cf_retry_exp, rx_class, rx_data} = 37'h0;
        {cf_ack, cf_tag, msk} = {4'h0, 24'h000000, 32'hFFFFFFFF};
        clear_verdict();
        repeat (4) @(posedge clk);
        #1;
        rst_b = 1'b1;
        t_quad();
        t_acks();
        t_block();
        t_self();
        t_phy();
        t_breset();
        t_conf();
        summarize();
    end
    // watchdog, far beyond the run
    initial begin
        repeat (20000) @(posedge clk);
        fail("watchdog expired");
        summarize();
    end
endmodule // arf_receive_formatter_bench
bind arf_receive_formatter arf_props chk (.*);
`default_nettype wire
